/* design/icra_line_filt.sv */
`timescale 1ns/1ps
`default_nettype none
module icra_line_filt
    import icra_pkg::*;
#(
    parameter int LEN = ICRA_FILT_LEN
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // raw line
    input wire logic i_line,
    // filtered line
    output logic o_line
);
    logic s1_reg;
    logic s2_reg;
    logic [LEN-1:0] hist_reg;
    wire all_hi = &hist_reg;
    wire all_lo = ~|hist_reg;

    // released bus idles high
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            hist_reg <= '1;
            o_line <= 1'b1;
        end else begin
            s1_reg <= i_line;
            s2_reg <= s1_reg;
            hist_reg <= {hist_reg[LEN-2:0], s2_reg};
            if (all_hi) o_line <= 1'b1;
            else if (all_lo) o_line <= 1'b0;
        end
    end
endmodule : icra_line_filt
`default_nettype wire

/* design/icra_pkg.sv */
package icra_pkg;
    // target address layout: fixed upper nibble, low three bits from straps
    localparam logic [3:0] ICRA_ADDR_FIXED = 4'h7;
    localparam int ICRA_ADDR_STRAP_W = 3;
    // operation codes in command byte 0 bits 2:0
    localparam logic [2:0] ICRA_OP_WRITE = 3'h3;
    localparam logic [2:0] ICRA_OP_READ = 3'h4;
    // command field positions
    localparam int ICRA_OP_LSB = 0;
    localparam int ICRA_PSEL_HI_BIT = 0;
    localparam int ICRA_PSEL_LO_BIT = 7;
    localparam int ICRA_BE_LSB = 2;
    localparam int ICRA_AHI_LSB = 0;
    localparam int ICRA_NUM_PORTS = 3;
    localparam int ICRA_CMD_BYTES = 4;
    localparam int ICRA_DATA_BYTES = 4;
    // glitch filter depth in core clocks
    localparam int ICRA_FILT_LEN = 3;
    localparam logic [31:0] ICRA_BUF_RST = 32'h0000_0000;

    typedef struct packed {
        logic [1:0] port;
        logic [9:0] addr;
    } icra_sel_t;

    typedef struct packed {
        logic [1:0] port;
        logic [9:0] addr;
        logic [3:0] be;
        logic [31:0] data;
    } icra_wr_t;
endpackage : icra_pkg

/* design/icra_target.sv */
// Functional notes
// - read = command write packet, then read packet
// - command packet only selects; data only on read
// - valid read command fetches word into buffer
// - read bytes go out MSB first
// - extra read bytes wrap to byte three
// - repeated START joins command and read packets
// - opcode 011b in byte0 bits2:0 writes
// - opcode 100b in byte0 bits2:0 reads
// - port index from byte1 bit0, byte2 bit7
// - byte2 bits5:2 are per-byte write enables
// - address 11:10 byte2, 9:2 byte3, word aligned
// - write data byte order MSB first
// - ack all command bytes and the first four write data bytes
// - address 0111 plus three strap pins
// - surplus write bytes get NAK, discarded
// - invalid command leaves register unchanged
`timescale 1ns/1ps
`default_nettype none
module icra_target
    import icra_pkg::*;
#(
    parameter int NUM_PORTS = ICRA_NUM_PORTS
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // serial bus, open drain
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_scl_oe,
    output logic o_sda,
    output logic o_sda_oe,
    // address straps
    input wire logic [ICRA_ADDR_STRAP_W-1:0] i_addr_strap,
    // register write port
    output icra_wr_t o_wr,
    output logic o_wr_stb,
    // register read port, data valid the cycle after the strobe
    output icra_sel_t o_rd,
    output logic o_rd_stb,
    input wire logic [31:0] i_rd_data
);
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA, ST_IGNORE} icra_state_t;

    logic scl_f;
    logic sda_f;
    icra_line_filt #(.LEN(ICRA_FILT_LEN)) u_scl (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_line(i_scl), .o_line(scl_f));
    icra_line_filt #(.LEN(ICRA_FILT_LEN)) u_sda (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_line(i_sda), .o_line(sda_f));

    logic scl_d_reg;
    logic sda_d_reg;
    icra_state_t state_reg;
    logic [2:0] bit_reg;
    logic [7:0] sh_reg;
    logic [2:0] cnt_reg;
    logic [7:0] cmd_reg [ICRA_CMD_BYTES];
    logic [31:0] wd_reg;
    logic [31:0] buf_reg;
    logic [1:0] rb_reg;
    logic in_ack_reg;
    logic ack_drive_reg;
    logic rd_pend_reg;
    logic [6:0] my_addr_reg;
    logic strap_done_reg;
    logic tx_bit_reg;
    logic mack_reg;
    logic got_byte_reg;

    // bus conditions and clock edges
    wire scl_rise = scl_f & ~scl_d_reg;
    wire scl_fall = ~scl_f & scl_d_reg;
    wire start_c = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
    wire stop_c = scl_f & scl_d_reg & ~sda_d_reg & sda_f;
    wire [7:0] rx_byte = {sh_reg[6:0], sda_f};
    wire byte_done = scl_rise & (bit_reg == 3'h7) & ~in_ack_reg;

    // command decode
    wire [2:0] opc = cmd_reg[0][ICRA_OP_LSB +: 3];
    wire [1:0] psel = {cmd_reg[1][ICRA_PSEL_HI_BIT], cmd_reg[2][ICRA_PSEL_LO_BIT]};
    wire [3:0] be = cmd_reg[2][ICRA_BE_LSB +: 4];
    wire [9:0] waddr = {cmd_reg[2][ICRA_AHI_LSB +: 2], cmd_reg[3]};
    wire port_ok = 32'(psel) < NUM_PORTS;
    // reserved bits must be zero or the command is invalid
    wire rsv_ok = (cmd_reg[0][7:3] == 5'h00) && (cmd_reg[1][7:1] == 7'h00) && !cmd_reg[2][6];
    wire wr_valid = port_ok && rsv_ok && (opc == ICRA_OP_WRITE);
    wire rd_valid = port_ok && rsv_ok && (opc == ICRA_OP_READ);
    wire addr_hit = rx_byte[7:1] == my_addr_reg;
    wire cmd_last = byte_done && state_reg == ST_CMD && cnt_reg == 3'(ICRA_CMD_BYTES - 1);
    wire wd_last = byte_done && state_reg == ST_WDATA && cnt_reg == 3'(ICRA_DATA_BYTES - 1);
    // byte index is 2 bits so the fifth read byte wraps to the top
    wire [1:0] rb_inc = rb_reg + 2'h1;
    wire [7:0] tx_byte = buf_reg[{~rb_reg, 3'h0} +: 8];
    wire [7:0] tx_next = buf_reg[{~rb_inc, 3'h0} +: 8];

    // straps caught after reset release
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            my_addr_reg <= 7'h00;
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            my_addr_reg <= {ICRA_ADDR_FIXED, i_addr_strap};
            strap_done_reg <= 1'b1;
        end
    end

    // fetch into holding buffer one cycle after the read strobe
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_pend_reg <= 1'b0;
            buf_reg <= ICRA_BUF_RST;
        end else begin
            rd_pend_reg <= o_rd_stb;
            if (rd_pend_reg) buf_reg <= i_rd_data;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            state_reg <= ST_IDLE;
            bit_reg <= 3'h0;
            sh_reg <= 8'h00;
            cnt_reg <= 3'h0;
            for (int i = 0; i < ICRA_CMD_BYTES; i++) cmd_reg[i] <= 8'h00;
            wd_reg <= 32'h0;
            rb_reg <= 2'h0;
            in_ack_reg <= 1'b0;
            ack_drive_reg <= 1'b0;
            tx_bit_reg <= 1'b1;
            mack_reg <= 1'b0;
            got_byte_reg <= 1'b0;
            o_wr <= '0;
            o_wr_stb <= 1'b0;
            o_rd <= '0;
            o_rd_stb <= 1'b0;
        end else begin
            scl_d_reg <= scl_f;
            sda_d_reg <= sda_f;
            o_wr_stb <= 1'b0;
            o_rd_stb <= 1'b0;
            if (start_c) begin
                // repeated START drops partial commands but keeps buffer
                state_reg <= ST_ADDR;
                got_byte_reg <= 1'b0;
                bit_reg <= 3'h0;
                in_ack_reg <= 1'b0;
                ack_drive_reg <= 1'b0;
                tx_bit_reg <= 1'b1;
            end else if (stop_c) begin
                state_reg <= ST_IDLE;
                ack_drive_reg <= 1'b0;
                tx_bit_reg <= 1'b1;
            end else if (scl_rise) begin
                if (in_ack_reg) begin
                    mack_reg <= ~sda_f;
                end else begin
                    sh_reg <= rx_byte;
                    bit_reg <= bit_reg + 3'h1;
                end
                if (byte_done) begin
                    got_byte_reg <= 1'b1;
                    unique case (state_reg)
                        ST_ADDR: begin
                            if (!addr_hit) state_reg <= ST_IGNORE;
                            else if (rx_byte[0]) begin
                                state_reg <= ST_RDATA;
                                rb_reg <= 2'h0;
                            end else begin
                                state_reg <= ST_CMD;
                                cnt_reg <= 3'h0;
                            end
                            ack_drive_reg <= addr_hit;
                        end
                        ST_CMD: begin
                            cmd_reg[cnt_reg[1:0]] <= rx_byte;
                            cnt_reg <= cnt_reg + 3'h1;
                            ack_drive_reg <= 1'b1;
                        end
                        ST_WDATA: begin
                            if (cnt_reg < 3'(ICRA_DATA_BYTES)) begin
                                wd_reg <= {wd_reg[23:0], rx_byte};
                                cnt_reg <= cnt_reg + 3'h1;
                                ack_drive_reg <= 1'b1;
                            end else begin
                                ack_drive_reg <= 1'b0;
                            end
                        end
                        default: ack_drive_reg <= 1'b0;
                    endcase
                end
            end else if (scl_fall) begin
                if (got_byte_reg) begin
                    // ack slot follows every byte, line released unless acking
                    got_byte_reg <= 1'b0;
                    in_ack_reg <= 1'b1;
                    tx_bit_reg <= ~ack_drive_reg;
                end else if (in_ack_reg) begin
                    in_ack_reg <= 1'b0;
                    ack_drive_reg <= 1'b0;
                    tx_bit_reg <= 1'b1;
                    if (state_reg == ST_RDATA) begin
                        if (ack_drive_reg) begin
                            tx_bit_reg <= tx_byte[7];
                        end else if (mack_reg) begin
                            rb_reg <= rb_inc;
                            tx_bit_reg <= tx_next[7];
                        end else begin
                            state_reg <= ST_IGNORE;
                        end
                    end
                end else if (state_reg == ST_RDATA) begin
                    tx_bit_reg <= tx_byte[3'h7 - bit_reg];
                end
            end
            if (cmd_last) begin
                state_reg <= ST_WDATA;
                cnt_reg <= 3'h0;
            end
            if (state_reg == ST_WDATA && scl_fall && in_ack_reg && cnt_reg == 3'h0 && rd_valid) begin
                o_rd <= '{port: psel, addr: waddr};
                o_rd_stb <= 1'b1;
                state_reg <= ST_IGNORE;
            end
            if (wd_last && wr_valid) begin
                o_wr <= '{port: psel, addr: waddr, be: be, data: {wd_reg[23:0], rx_byte}};
                o_wr_stb <= 1'b1;
            end
        end
    end

    // open-drain lines: only pull low, never stretch the clock
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sda <= 1'b0;
            o_sda_oe <= 1'b0;
            o_scl <= 1'b0;
            o_scl_oe <= 1'b0;
        end else begin
            o_sda <= 1'b0;
            o_sda_oe <= ~tx_bit_reg;
            o_scl <= 1'b0;
            o_scl_oe <= 1'b0;
        end
    end
endmodule : icra_target
`default_nettype wire

/* tb/icra_i2c_master.sv */
`timescale 1ns/1ps
`default_nettype none
module icra_i2c_master (
    // clock and resolved lines
    input wire logic i_mclk,
    input wire logic i_scl,
    input wire logic i_sda,
    // open-drain pulls, high pulls low
    output logic o_scl_low,
    output logic o_sda_low
);
    // third of a bit, well above filter latency
    localparam int HP = 12;
    initial begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
    end
    task automatic hp;
        repeat (HP) @(posedge i_mclk);
        #1;
    endtask : hp
    // doubles as repeated start since clock is low then
    task automatic bus_start;
        hp;
        o_sda_low = 1'b0;
        hp;
        o_scl_low = 1'b0;
        hp;
        o_sda_low = 1'b1;
        hp;
        o_scl_low = 1'b1;
    endtask : bus_start
    task automatic bus_stop;
        hp;
        o_sda_low = 1'b1;
        hp;
        o_scl_low = 1'b0;
        hp;
        o_sda_low = 1'b0;
        hp;
    endtask : bus_stop
    task automatic bit_xfer(input logic b, output logic r);
        hp;
        o_sda_low = !b;
        hp;
        o_scl_low = 1'b0;
        hp;
        r = i_sda;
        o_scl_low = 1'b1;
    endtask : bit_xfer
    task automatic put_byte(input logic [7:0] b, output logic nak);
        logic r;
        for (int i = 7; i >= 0; i--) bit_xfer(b[i], r);
        bit_xfer(1'b1, nak);
    endtask : put_byte
    task automatic get_byte(input logic ack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bit_xfer(1'b1, b[i]);
        bit_xfer(!ack, r);
    endtask : get_byte
endmodule : icra_i2c_master
`default_nettype wire

/* tb/icra_target_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module icra_target_asserts
    import icra_pkg::*;
(
    // clock, reset, bus
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_scl,
    // design outputs
    input wire logic o_scl,
    input wire logic o_scl_oe,
    input wire logic o_sda,
    input wire logic o_sda_oe,
    input wire icra_wr_t o_wr,
    input wire logic o_wr_stb,
    input wire icra_sel_t o_rd,
    input wire logic o_rd_stb
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    // pins only ever pull low, and never the clock
    property p_drive; !o_scl_oe && !o_scl && !o_sda; endproperty
    a_drive: assert property (p_drive) else $error("clock stretched or line driven high");
    property p_wr_pulse; o_wr_stb |=> !o_wr_stb; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe longer than one cycle");
    property p_rd_pulse; o_rd_stb |=> !o_rd_stb; endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe longer than one cycle");
    property p_wr_port; o_wr_stb |-> o_wr.port != 2'h3; endproperty
    a_wr_port: assert property (p_wr_port) else $error("write to port three");
    property p_rd_port; o_rd_stb |-> o_rd.port != 2'h3; endproperty
    a_rd_port: assert property (p_rd_port) else $error("read from port three");
    property p_excl; !(o_wr_stb && o_rd_stb); endproperty
    a_excl: assert property (p_excl) else $error("read and write strobes together");
    property p_wr_hold; !o_wr_stb |-> $stable(o_wr); endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write fields moved without strobe");
    property p_rd_hold; !o_rd_stb |-> $stable(o_rd); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read select moved without strobe");
    // data line may only move while the clock is low
    property p_oe_edge; $changed(o_sda_oe) |-> !i_scl; endproperty
    a_oe_edge: assert property (p_oe_edge) else $error("data pull changed with clock high");
endmodule : icra_target_asserts
bind icra_target icra_target_asserts u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_scl(i_scl), .o_scl(o_scl),
    .o_scl_oe(o_scl_oe), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_wr(o_wr), .o_wr_stb(o_wr_stb),
    .o_rd(o_rd), .o_rd_stb(o_rd_stb));
`default_nettype wire

/* tb/test_icra_target.sv */
`timescale 1ns/1ps
`default_nettype none
module test_icra_target;
    import icra_pkg::*;
    logic i_mclk, i_rst_n, scl_low, sda_low, o_scl, o_scl_oe, o_sda, o_sda_oe, o_wr_stb, o_rd_stb, nak;
    logic [1:0] p;
    logic [2:0] strap;
    logic [7:0] rb;
    logic [31:0] rd_data, lfsr, d;
    logic [31:0] mem [0:4095];
    logic [31:0] exp_w [0:4095];
    icra_wr_t o_wr;
    icra_sel_t o_rd;
    int err_total, num_checks;
    wire logic scl = !(scl_low || o_scl_oe);
    wire logic sda = !(sda_low || o_sda_oe);
    icra_i2c_master m (.i_mclk(i_mclk), .i_scl(scl), .i_sda(sda), .o_scl_low(scl_low), .o_sda_low(sda_low));
    icra_target dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda), .o_scl(o_scl),
        .o_scl_oe(o_scl_oe), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_addr_strap(strap), .o_wr(o_wr),
        .o_wr_stb(o_wr_stb), .o_rd(o_rd), .o_rd_stb(o_rd_stb), .i_rd_data(rd_data));
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be);
        for (int i = 0; i < 4; i++)
            if (be[i]) o[8*i +: 8] = n[8*i +: 8];
        return o;
    endfunction : merge
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt
    task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string what);
        num_checks++;
        if (seen !== want) begin
            err_total++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask : chk
    // register file stand-in, read data one cycle after the strobe
    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            rd_data <= '0;
            for (int i = 0; i < 4096; i++) mem[i] <= '0;
        end else begin
            if (o_wr_stb) mem[{o_wr.port, o_wr.addr}] <= merge(mem[{o_wr.port, o_wr.addr}], o_wr.data, o_wr.be);
            if (o_rd_stb) rd_data <= mem[{o_rd.port, o_rd.addr}];
        end
    end
    task automatic cmd(input logic [7:0] b0, input logic [1:0] pp, input logic [3:0] be, input logic [9:0] a);
        logic [31:0] cb;
        cb = {b0, 7'h00, pp[1], pp[0], 1'b0, be, a};
        m.bus_start;
        m.put_byte({ICRA_ADDR_FIXED, strap, 1'b0}, nak);
        chk(nak, 0, "address refused");
        for (int i = 3; i >= 0; i--) begin
            m.put_byte(cb[8*i +: 8], nak);
            chk(nak, 0, "command byte refused");
        end
    endtask : cmd
    task automatic wr(input logic [7:0] b0, input logic [1:0] pp, input logic [3:0] be, input logic [9:0] a,
        input logic [31:0] dw, input int n);
        cmd(b0, pp, be, a);
        for (int i = 0; i < n; i++) begin
            m.put_byte(dw[31 - 8*(i%4) -: 8], nak);
            chk(nak, i > 3, "data byte answer");
        end
        m.bus_stop;
        if (b0 == ICRA_OP_WRITE && pp != 2'h3 && n > 3) exp_w[{pp, a}] = merge(exp_w[{pp, a}], dw, be);
    endtask : wr
    task automatic rd(input logic [1:0] pp, input logic [9:0] a, input logic sr, input int k);
        cmd({5'h00, ICRA_OP_READ}, pp, 4'hF, a);
        if (!sr) m.bus_stop;
        m.bus_start;
        m.put_byte({ICRA_ADDR_FIXED, strap, 1'b1}, nak);
        chk(nak, 0, "read address refused");
        for (int i = 0; i < k; i++) begin
            m.get_byte(i < k - 1, rb);
            chk(rb, exp_w[{pp, a}][31 - 8*(i%4) -: 8], "read byte");
        end
        m.bus_stop;
    endtask : rd
    task automatic end_of_test;
        if (err_total == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test
    initial begin
        i_mclk = 1'b0;
        forever #2 i_mclk = !i_mclk;
    end
    initial begin
        repeat (80000) @(posedge i_mclk);
        err_total++;
        end_of_test;
    end
    initial begin
        i_rst_n = 1'b0;
        strap = 3'h5;
        lfsr = 32'hB6239397;
        for (int i = 0; i < 4096; i++) exp_w[i] = '0;
        repeat (4) @(posedge i_mclk);
        #1 i_rst_n = 1'b1;
        repeat (4) @(posedge i_mclk);
        wr(8'h03, 2'h0, 4'hF, 10'h02D, 32'h12345678, 4);
        rd(2'h0, 10'h02D, 1'b0, 6);
        for (int j = 0; j < 4; j++) begin
            lfsr = nxt(lfsr);
            p = 2'(lfsr % 3);
            d = nxt(lfsr);
            wr(8'h03, p, lfsr[5:2], lfsr[15:6], d, 4);
            rd(p, lfsr[15:6], 1'b1, 4);
        end
        wr(8'h03, 2'h1, 4'h5, 10'h3FF, 32'hA5C30F96, 5);
        wr(8'h0B, 2'h1, 4'hF, 10'h3FF, 32'hFFFFFFFF, 4);
        wr(8'h03, 2'h3, 4'hF, 10'h3FF, 32'hFFFFFFFF, 4);
        wr(8'h03, 2'h1, 4'hF, 10'h3FF, 32'h00000000, 2);
        rd(2'h1, 10'h3FF, 1'b0, 4);
        m.bus_start;
        m.put_byte({ICRA_ADDR_FIXED, ~strap, 1'b0}, nak);
        chk(nak, 1, "foreign address taken");
        m.bus_stop;
        end_of_test;
    end
endmodule : test_icra_target
`default_nettype wire
